// >>> tcp_regs.vh
`ifndef TCP_REGS_VH
`define TCP_REGS_VH

// register indices (byte address = index * 4 is not used; plain port uses index)
`define TCP_ADDR_W 4
`define TCP_A_CTRL 4'h0
`define TCP_A_PERIOD 4'h1
`define TCP_A_CMP 4'h2
`define TCP_A_COUNT 4'h3
`define TCP_A_CAPT 4'h4
`define TCP_A_STAT 4'h5
`define TCP_A_MASK 4'h6
`define TCP_A_DEAD 4'h7

// control fields
`define TCP_C_START 0
`define TCP_C_MODE_LO 1
`define TCP_C_MODE_HI 2
`define TCP_C_CMP_LO 3
`define TCP_C_CMP_HI 5
`define TCP_C_CLK_LO 6
`define TCP_C_CLK_HI 7
`define TCP_C_COMPL 8
`define TCP_CTRL_W 9

// run modes
`define TCP_MODE_FREE 2'h0
`define TCP_MODE_ONESHOT 2'h1
`define TCP_MODE_ENABLE 2'h2

// comparison selects
`define TCP_CMP_LESS 3'h0
`define TCP_CMP_LESS_OR_EQUAL 3'h1
`define TCP_CMP_EQUAL 3'h2
`define TCP_CMP_GREATER_OR_EQUAL 3'h3
`define TCP_CMP_GREATER 3'h4

// status bits
`define TCP_S_TC 0
`define TCP_S_CMP 1
`define TCP_S_CAPT 2
`define TCP_STAT_W 3

// reset values and counter constants
`define TCP_CTRL_RST 9'h000
`define TCP_PERIOD_RST 16'hffff
`define TCP_CMP_RST 16'h0000
`define TCP_DEAD_RST 8'h00
`define TCP_ZERO16 16'h0000
`define TCP_ONE16 16'h0001
`define TCP_ONE8 8'h01
`define TCP_ZERO8 8'h00

`endif

// >>> tcp_timer.v
`timescale 1ns/100ps
`include "tcp_regs.vh"

module tcp_timer
(
   clk,
   arst_n,
   addr,
   wdata,
   wr,
   rd,
   rdata,
   clk_src,
   enable_in,
   timer_rst,
   capture_in,
   kill_in,
   cmp_out,
   tc_out,
   irq
);
   input wire clk;
   input wire arst_n;
   input wire [`TCP_ADDR_W-1:0] addr;
   input wire [31:0] wdata;
   input wire wr;
   input wire rd;
   output reg [31:0] rdata;
   input wire [3:0] clk_src;
   input wire enable_in;
   input wire timer_rst;
   input wire capture_in;
   input wire kill_in;
   output reg cmp_out;
   output reg tc_out;
   output reg irq;

   reg rst_s1_r;
   reg rst_s2_r;
   wire rst_n;
   reg [`TCP_CTRL_W-1:0] ctrl_r;
   reg [15:0] period_r;
   reg [15:0] cmp_val_r;
   reg [7:0] dead_r;
   reg [15:0] count_r;
   reg [15:0] count_nxt;
   reg [15:0] capt_r;
   reg [`TCP_STAT_W-1:0] stat_r;
   reg [`TCP_STAT_W-1:0] mask_r;
   reg running_r;
   reg reload_r;
   reg src_prev_r;
   reg cmp_raw_prev_r;
   reg [7:0] db_cnt_r;
   reg capt_prev_r;
   reg tc_now;
   wire [1:0] mode;
   wire [2:0] cmp_sel;
   wire src_lvl;
   wire tick;
   wire may_count;
   wire step;
   wire cmp_raw;
   wire cmp_edge;
   wire capt_ev;
   wire start_wr;
   wire [`TCP_STAT_W-1:0] events;

   function cmp_fn;
      input [2:0] sel;
      input [15:0] a;
      input [15:0] b;
      begin
         case (sel)
            `TCP_CMP_LESS: cmp_fn = a < b;
            `TCP_CMP_LESS_OR_EQUAL: cmp_fn = a <= b;
            `TCP_CMP_EQUAL: cmp_fn = a == b;
            `TCP_CMP_GREATER_OR_EQUAL: cmp_fn = a >= b;
            `TCP_CMP_GREATER: cmp_fn = a > b;
            default: cmp_fn = 1'b0;
         endcase
      end
   endfunction

   // reset release through two flops
   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end
      else
      begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end
   assign rst_n = rst_s2_r;

   assign mode = ctrl_r[`TCP_C_MODE_HI:`TCP_C_MODE_LO];
   assign cmp_sel = ctrl_r[`TCP_C_CMP_HI:`TCP_C_CMP_LO];
   assign src_lvl = clk_src[ctrl_r[`TCP_C_CLK_HI:`TCP_C_CLK_LO]];
   assign tick = src_lvl & ~src_prev_r;
   assign may_count = running_r & ((mode != `TCP_MODE_ENABLE) | enable_in);
   assign step = tick & may_count;
   assign start_wr = wr & (addr == `TCP_A_CTRL) & wdata[`TCP_C_START];
   assign cmp_raw = cmp_fn(cmp_sel, count_r, cmp_val_r);
   assign cmp_edge = cmp_raw ^ cmp_raw_prev_r;
   assign capt_ev = capture_in & ~capt_prev_r;
   assign events = {capt_ev, cmp_raw & ~cmp_raw_prev_r, tc_now};

   always @*
   begin
      tc_now = 1'b0;
      count_nxt = count_r;
      if (start_wr | timer_rst | reload_r)
         count_nxt = period_r;
      else if (step)
      begin
         if (count_r == `TCP_ZERO16)
            tc_now = 1'b0;
         else
         begin
            count_nxt = count_r - `TCP_ONE16;
            tc_now = (count_nxt == `TCP_ZERO16);
         end
      end
   end

   // read multiplexer, unmapped indices read zero
   function [31:0] rd_fn;
      input [`TCP_ADDR_W-1:0] a;
      input [`TCP_CTRL_W-1:0] ctl;
      input run;
      input [15:0] per;
      input [15:0] cv;
      input [15:0] cnt;
      input [15:0] cap;
      input [`TCP_STAT_W-1:0] st;
      input [`TCP_STAT_W-1:0] msk;
      input [7:0] dv;
      begin
         case (a)
            `TCP_A_CTRL: rd_fn = {23'h000000, ctl[`TCP_CTRL_W-1:1], run};
            `TCP_A_PERIOD: rd_fn = {16'h0000, per};
            `TCP_A_CMP: rd_fn = {16'h0000, cv};
            `TCP_A_COUNT: rd_fn = {16'h0000, cnt};
            `TCP_A_CAPT: rd_fn = {16'h0000, cap};
            `TCP_A_STAT: rd_fn = {29'h00000000, st};
            `TCP_A_MASK: rd_fn = {29'h00000000, msk};
            `TCP_A_DEAD: rd_fn = {24'h000000, dv};
            default: rd_fn = 32'h0000_0000;
         endcase
      end
   endfunction

   // edge detector history
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         src_prev_r <= 1'b0;
         capt_prev_r <= 1'b0;
         cmp_raw_prev_r <= 1'b0;
      end
      else
      begin
         src_prev_r <= src_lvl;
         capt_prev_r <= capture_in;
         cmp_raw_prev_r <= cmp_raw;
      end
   end

   // counter and deferred reload
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_r <= `TCP_PERIOD_RST;
         reload_r <= 1'b0;
      end
      else
      begin
         count_r <= count_nxt;
         reload_r <= tc_now & ~(mode == `TCP_MODE_ONESHOT);
      end
   end

   // run flag
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         running_r <= 1'b0;
      end
      else
      begin
         if (start_wr)
            running_r <= 1'b1;
         else if (tc_now & (mode == `TCP_MODE_ONESHOT))
            running_r <= 1'b0;
      end
   end

   // capture holding register
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         capt_r <= `TCP_ZERO16;
      end
      else if (capt_ev)
      begin
         capt_r <= count_r;
      end
   end

   // deadband counter restarts on each compare change
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         db_cnt_r <= `TCP_ZERO8;
      end
      else
      begin
         if (cmp_edge)
            db_cnt_r <= dead_r;
         else if (db_cnt_r != `TCP_ZERO8)
            db_cnt_r <= db_cnt_r - `TCP_ONE8;
      end
   end

   // compare and terminal count outputs
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cmp_out <= 1'b0;
         tc_out <= 1'b0;
      end
      else
      begin
         if (kill_in)
         begin
            cmp_out <= 1'b0;
            tc_out <= ctrl_r[`TCP_C_COMPL] ? 1'b0 : tc_now;
         end
         else if (ctrl_r[`TCP_C_COMPL])
         begin
            // both low through the deadband
            cmp_out <= cmp_raw & ~cmp_edge & (db_cnt_r == `TCP_ZERO8);
            tc_out <= ~cmp_raw & ~cmp_edge & (db_cnt_r == `TCP_ZERO8);
         end
         else
         begin
            cmp_out <= cmp_raw;
            tc_out <= tc_now;
         end
      end
   end

   // configuration registers
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_r <= `TCP_CTRL_RST;
         period_r <= `TCP_PERIOD_RST;
         cmp_val_r <= `TCP_CMP_RST;
         dead_r <= `TCP_DEAD_RST;
         mask_r <= {`TCP_STAT_W{1'b0}};
      end
      else if (wr)
      begin
         case (addr)
            `TCP_A_CTRL: ctrl_r <= {wdata[`TCP_CTRL_W-1:1], 1'b0};
            `TCP_A_PERIOD: period_r <= wdata[15:0];
            `TCP_A_CMP: cmp_val_r <= wdata[15:0];
            `TCP_A_DEAD: dead_r <= wdata[7:0];
            `TCP_A_MASK: mask_r <= wdata[`TCP_STAT_W-1:0];
            default: ;
         endcase
      end
   end

   // set wins over write-one-to-clear
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stat_r <= {`TCP_STAT_W{1'b0}};
      end
      else
      begin
         if (wr && addr == `TCP_A_STAT)
            stat_r <= (stat_r & ~wdata[`TCP_STAT_W-1:0]) | events;
         else
            stat_r <= stat_r | events;
      end
   end

   // level interrupt
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq <= 1'b0;
      end
      else
      begin
         irq <= |(stat_r & mask_r);
      end
   end

   // read data stands one cycle, zero otherwise
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata <= 32'h0000_0000;
      end
      else if (rd)
      begin
         rdata <= rd_fn(addr, ctrl_r, running_r, period_r, cmp_val_r, count_r, capt_r, stat_r, mask_r, dead_r);
      end
      else
      begin
         rdata <= 32'h0000_0000;
      end
   end
endmodule

// >>> tcp_timer_properties.sv
`timescale 1ns/100ps
module tcp_timer_props (
   input wire clk,
   input wire arst_n,
   input wire [3:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   input wire [31:0] rdata,
   input wire kill_in,
   input wire cmp_out,
   input wire tc_out,
   input wire irq
);
   reg compl_r = 1'b0;
   // tracks complementary mode, tc then carries a level
   always @(posedge clk)
   begin
      if (!arst_n)
         compl_r <= 1'b0;
      else if (wr && addr == 4'h0)
         compl_r <= wdata[8];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   a_quiet_reset: assert property ($rose(arst_n) |-> (!irq && !tc_out && !cmp_out) [*2])
      else $error("output after reset");
   a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
      else $error("rdata not idle");
   a_unmapped_read: assert property (rd && addr > 4'h7 |=> rdata == 32'h0)
      else $error("unmapped read");
   a_period_back: assert property (wr && addr == 4'h1 ##1 rd && addr == 4'h1 |=>
      rdata == ($past(wdata, 2) & 32'hffff)) else $error("period readback");
   a_mask_back: assert property (wr && addr == 4'h6 ##1 rd && addr == 4'h6 |=>
      rdata == ($past(wdata, 2) & 32'h7)) else $error("mask readback");
   a_kill_cmp: assert property (kill_in && $past(kill_in) |-> !cmp_out)
      else $error("kill ignored");
   a_tc_single: assert property (tc_out && !compl_r |=> !tc_out)
      else $error("tc too long");
   a_irq_masked: assert property (wr && addr == 4'h6 && wdata[2:0] == 3'h0 |=> ##1 !irq)
      else $error("irq not masked");
   a_irq_clear: assert property (wr && addr == 4'h5 && wdata[2:0] == 3'h7 |=> ##1 !irq)
      else $error("irq not cleared");
endmodule

// >>> tcp_fabric.sv
`timescale 1ns/100ps
module tcp_fabric (
   input wire clk,
   input wire run,
   output reg [3:0] clk_src
);
   initial clk_src = 4'h0;
   // tick on source 0 every second cycle while run is high, none when idle
   always @(posedge clk)
      clk_src <= {3'h0, run & ~clk_src[0]};
endmodule

// >>> timer_counter_pwm16_test.sv
`timescale 1ns/100ps
module timer_counter_pwm16_test;
   reg clk = 0, arst_n = 0, wr = 0, rd = 0, en = 0, trst = 0, capt = 0, kill = 0, run = 0, pend = 0;
   reg [3:0] addr = 4'h0;
   reg [31:0] wdata = 32'h0, p;
   reg [31:0] exp_q[$];
   wire [31:0] rdata;
   wire [3:0] csrc;
   wire cmp, tc, irq;
   integer error_cnt = 0, checks_done = 0, seed = 32'h5181, i, pulses;
   tcp_timer tcp_timer_i (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .clk_src(csrc), .enable_in(en), .timer_rst(trst), .capture_in(capt),
      .kill_in(kill), .cmp_out(cmp), .tc_out(tc), .irq(irq));
   tcp_fabric tcp_fabric_i (.clk(clk), .run(run), .clk_src(csrc));
   initial forever #12.5 clk = ~clk;
   task check(input [31:0] seen, input [31:0] want);
   begin
      checks_done = checks_done + 1;
      if (seen !== want)
      begin
         error_cnt = error_cnt + 1;
         $display("wrong value at %0t: saw %h want %h", $time, seen, want);
      end
   end
   endtask
   task summarize;
   begin
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   end
   endtask
   // bus tasks are entered just after a rising edge
   task wr_reg(input [3:0] a, input [31:0] d);
   begin
      addr <= a;
      wdata <= d;
      rd <= 1'b0;
      wr <= 1'b1;
      @(posedge clk);
   end
   endtask
   task rd_reg(input [3:0] a, input [31:0] e);
   begin
      exp_q.push_back(e);
      addr <= a;
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clk);
   end
   endtask
   // both strobes are released together only here, so back to back bus calls keep a strobe high with no idle cycle between them
   task cyc(input integer n);
   begin
      wr <= 1'b0;
      rd <= 1'b0;
      repeat (n) @(posedge clk);
   end
   endtask
   always @(posedge clk)
   begin
      if (pend)
         check(rdata, exp_q.pop_front());
      pend <= rd;
   end
   initial
   begin
      cyc(12);
      arst_n <= 1'b1;
      cyc(3);
      rd_reg(4'h1, 32'hffff);
      rd_reg(4'h3, 32'hffff);
      rd_reg(4'h9, 32'h0);
      wr_reg(4'h1, 32'h3);
      rd_reg(4'h1, 32'h3);
      wr_reg(4'h2, 32'h2);
      wr_reg(4'h6, 32'h7);
      rd_reg(4'h6, 32'h7);
      wr_reg(4'h0, 32'h13);
      run <= 1'b1;
      cyc(1);
      for (i = 0; i < 40 && tc !== 1'b1; i = i + 1)
         @(negedge clk);
      if (i == 40)
      begin
         error_cnt = error_cnt + 1;
         summarize;
      end
      cyc(10);
      rd_reg(4'h3, 32'h0);
      rd_reg(4'h5, 32'h3);
      check(irq, 32'h1);
      wr_reg(4'h5, 32'h7);
      rd_reg(4'h5, 32'h0);
      cyc(2);
      check(irq, 32'h0);
      $display("done one shot");
      p = ($random(seed) & 32'hffff) | 32'h8000;
      wr_reg(4'h1, p);
      wr_reg(4'h0, 32'h5);
      cyc(10);
      rd_reg(4'h3, p);
      wr_reg(4'h5, 32'h7);
      capt <= 1'b1;
      cyc(1);
      capt <= 1'b0;
      cyc(3);
      rd_reg(4'h4, p);
      rd_reg(4'h5, 32'h4);
      en <= 1'b1;
      cyc(8);
      en <= 1'b0;
      trst <= 1'b1;
      cyc(1);
      trst <= 1'b0;
      cyc(2);
      rd_reg(4'h3, p);
      wr_reg(4'h2, p);
      for (i = 0; i < 5; i = i + 1)
      begin
         wr_reg(4'h0, 32'h4 | (i << 3));
         cyc(3);
         check(cmp, i > 0 && i < 4);
      end
      wr_reg(4'h0, 32'h1c);
      cyc(3);
      kill <= 1'b1;
      cyc(3);
      check(cmp, 32'h0);
      kill <= 1'b0;
      cyc(3);
      check(cmp, 32'h1);
      wr_reg(4'h6, 32'h0);
      cyc(3);
      check(irq, 32'h0);
      $display("done enable mode");
      wr_reg(4'h7, 32'h2);
      wr_reg(4'h0, 32'h11c);
      cyc(4);
      check(cmp, 32'h1);
      check(tc, 32'h0);
      wr_reg(4'h0, 32'h124);
      cyc(2);
      check(cmp, 32'h0);
      check(tc, 32'h0);
      cyc(4);
      check(tc, 32'h1);
      check(cmp, 32'h0);
      wr_reg(4'h0, 32'h44);
      en <= 1'b1;
      cyc(8);
      en <= 1'b0;
      rd_reg(4'h3, p);
      wr_reg(4'h1, 32'h3);
      wr_reg(4'h0, 32'h1);
      cyc(1);
      pulses = 0;
      for (i = 0; i < 24; i = i + 1)
      begin
         @(negedge clk);
         if (tc === 1'b1)
            pulses = pulses + 1;
      end
      check(pulses >= 2, 32'h1);
      $display("done output modes");
      summarize;
   end
endmodule
bind tcp_timer tcp_timer_props tcp_timer_props_i (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
   .wr(wr), .rd(rd), .rdata(rdata), .kill_in(kill_in), .cmp_out(cmp_out), .tc_out(tc_out), .irq(irq));
